// ---- rtl/sss_consts.svh ----
// Constants of the snapshot sensor sequencer: offsets, fields, resets, timing
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

// Configuration register addresses
`define SSS_ADDR_SEQ_CTRL 4'h0
`define SSS_ADDR_COL_START 4'h1
`define SSS_ADDR_ROW_START 4'h2
`define SSS_ADDR_KERNEL_CNT 4'h3
`define SSS_ADDR_RST_LEN 4'h4
`define SSS_ADDR_DS_POS 4'h5
`define SSS_ADDR_TS_POS 4'h6
`define SSS_ADDR_FT_POS 4'h7
`define SSS_ADDR_PIVOT_DAC 4'h8
`define SSS_ADDR_BLACK_DAC 4'h9
`define SSS_ADDR_OFFS_DAC 4'ha
`define SSS_ADDR_CONV_PATH 4'hb
`define SSS_ADDR_AMP_SET 4'hc
`define SSS_ADDR_TRIM_LO 4'hd
`define SSS_ADDR_TRIM_MID 4'he
`define SSS_ADDR_TRIM_HI 4'hf

// Reset values
`define SSS_RST_SEQ_CTRL 12'h029
`define SSS_RST_COL_START 12'h000
`define SSS_RST_ROW_START 12'h000
`define SSS_RST_KERNEL_CNT 12'h0a0
`define SSS_RST_RST_LEN 12'h002
`define SSS_RST_DS_POS 12'h000
`define SSS_RST_TS_POS 12'h000
`define SSS_RST_FT_POS 12'h1e1
`define SSS_RST_PIVOT_DAC 12'h04a
`define SSS_RST_BLACK_DAC 12'h06b
`define SSS_RST_OFFS_DAC 12'h055
`define SSS_RST_CONV_PATH 12'h0f0
`define SSS_RST_AMP_SET 12'hfb0
`define SSS_RST_TRIM_LO 12'hadf
`define SSS_RST_TRIM_MID 12'h6db
`define SSS_RST_TRIM_HI 12'h0db

// Sequencer control fields
`define SSS_F_MASTER 0
`define SSS_F_SUBSAMPLE 1
`define SSS_F_GRAN_LO 2
`define SSS_F_GRAN_HI 3
`define SSS_F_ANALOG_OUT 4
`define SSS_F_CALIB_LINE 5
`define SSS_F_DS_EN 6
`define SSS_F_TS_EN 7
`define SSS_F_REV_X 8
`define SSS_F_REV_Y 9
`define SSS_F_NDR 10

// Serial frame layout: read flag, 4 address bits, 12 data bits, MSB first
`define SSS_SPI_HDR_BITS 5'd5
`define SSS_SPI_ALL_BITS 5'd17

// Array geometry and timing
`define SSS_CLK_DIV 2'd3
`define SSS_ROW_LAST 9'd479
`define SSS_COL_LAST 10'd639
`define SSS_COLS_PER_GROUP 3
`define SSS_PIX_PER_KERNEL 10'd4
`define SSS_ROW_OVH_TICKS 8'd8
`define SSS_PIX_W 10
`define SSS_FIFO_DEPTH 32

`endif

// ---- rtl/sss_pkg.sv ----
// Types of the snapshot sensor sequencer
package sss_pkg;
  // Integration engine states, Gray along wait-reset-integrate-transfer
  typedef enum logic [1:0] {
    I_WAIT = 2'b00,
    I_RESET = 2'b01,
    I_INTEG = 2'b11,
    I_XFER = 2'b10
  } sss_int_st_t;
  // Readout engine states
  typedef enum logic [1:0] {
    R_GAP = 2'b00,
    R_ROW = 2'b01,
    R_BLANK = 2'b11,
    R_SPARE = 2'b10
  } sss_rd_st_t;
endpackage

// ---- rtl/sss_sequencer.sv ----
// Snapshot sensor sequencer: serial registers, integration, readout, pixel FIFO
`timescale 1ns/10ps
`include "sss_consts.svh"

// Pixel FIFO with valid/ready on both sides
module sss_fifo #(
  parameter int W = `SSS_PIX_W,
  parameter int D = `SSS_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage words
  logic [AW-1:0] wr_ptr_r; // Write index
  logic [AW-1:0] rd_ptr_r; // Read index
  logic [AW:0] cnt_r; // Fill level
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Memory write
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and level
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sss_sequencer (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic spi_clk_i,
  input wire logic spi_en_i,
  input wire logic spi_data_i,
  output logic spi_data_o,
  output logic spi_data_oe_n_o,
  input wire logic int_time_i,
  output logic int_time_o,
  output logic int_time_oe_n_o,
  input wire logic dual_slope_i,
  output logic dual_slope_o,
  output logic dual_slope_oe_n_o,
  input wire logic triple_slope_i,
  output logic triple_slope_o,
  output logic triple_slope_oe_n_o,
  input wire logic overlap_en_i,
  input wire logic [`SSS_PIX_W-1:0] adc_data_i,
  input wire logic pix_ready_i,
  output logic [`SSS_PIX_W-1:0] pix_data_o,
  output logic line_valid_o,
  output logic frame_valid_o,
  output logic [8:0] row_addr_o,
  output logic [9:0] col_addr_o,
  output logic pix_reset_o,
  output logic dual_slope_reset_o,
  output logic triple_slope_reset_o,
  output logic pix_sample_o,
  output logic seq_tick_o
);
  logic [11:0] shadow_r [16]; // Registers as written over the serial link
  logic [11:0] active_r [16]; // Copy the sequencer runs from
  logic [1:0] div_r; // Clock divider
  logic tick; // One-cycle sequencer enable
  logic [2:0] sclk_s; // Serial clock sync plus edge stage
  logic [1:0] sen_s; // Serial enable sync
  logic [1:0] sdat_s; // Serial data sync
  logic [1:0] p1_s, p2_s, p3_s; // Strobe input syncs
  logic [2:0] pin_prev_r; // Strobe levels at the last tick
  logic [4:0] bit_cnt_r; // Serial bits received
  logic [15:0] rx_r; // Serial receive shift
  logic [11:0] tx_r; // Serial transmit shift
  logic rd_mode_r; // Current serial frame is a read
  sss_pkg::sss_int_st_t int_st_r;
  sss_pkg::sss_rd_st_t rd_st_r;
  logic [11:0] line_cnt_r; // Line periods since integration start
  logic [7:0] lp_cnt_r; // Ticks within a line period
  logic ndr_armed_r; // Array already reset in this run
  logic pending_r; // Sampled frame awaiting readout
  logic [8:0] row_r; // Current row
  logic [8:0] rows_left_r; // Rows left in the frame
  logic [7:0] kern_r; // Kernel within the row
  logic [7:0] blank_r; // Blanking ticks
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`SSS_PIX_W-1:0] fifo_out_data;
  logic push;
  logic out_take;
  logic master;
  logic line_end;
  logic start_rd;
  logic xfer_go;
  logic [2:0] pin_now;

  // Width mask for each register address
  function automatic logic [11:0] sss_mask(input logic [3:0] a);
    case (a)
      `SSS_ADDR_SEQ_CTRL: sss_mask = 12'h7ff;
      `SSS_ADDR_ROW_START, `SSS_ADDR_TRIM_HI: sss_mask = 12'h1ff;
      `SSS_ADDR_COL_START, `SSS_ADDR_KERNEL_CNT, `SSS_ADDR_PIVOT_DAC,
      `SSS_ADDR_BLACK_DAC, `SSS_ADDR_OFFS_DAC: sss_mask = 12'h0ff;
      default: sss_mask = 12'hfff;
    endcase
  endfunction

  // Reset value for each register address
  function automatic logic [11:0] sss_rst(input logic [3:0] a);
    case (a)
      `SSS_ADDR_SEQ_CTRL: sss_rst = `SSS_RST_SEQ_CTRL;
      `SSS_ADDR_COL_START: sss_rst = `SSS_RST_COL_START;
      `SSS_ADDR_ROW_START: sss_rst = `SSS_RST_ROW_START;
      `SSS_ADDR_KERNEL_CNT: sss_rst = `SSS_RST_KERNEL_CNT;
      `SSS_ADDR_RST_LEN: sss_rst = `SSS_RST_RST_LEN;
      `SSS_ADDR_DS_POS: sss_rst = `SSS_RST_DS_POS;
      `SSS_ADDR_TS_POS: sss_rst = `SSS_RST_TS_POS;
      `SSS_ADDR_FT_POS: sss_rst = `SSS_RST_FT_POS;
      `SSS_ADDR_PIVOT_DAC: sss_rst = `SSS_RST_PIVOT_DAC;
      `SSS_ADDR_BLACK_DAC: sss_rst = `SSS_RST_BLACK_DAC;
      `SSS_ADDR_OFFS_DAC: sss_rst = `SSS_RST_OFFS_DAC;
      `SSS_ADDR_CONV_PATH: sss_rst = `SSS_RST_CONV_PATH;
      `SSS_ADDR_AMP_SET: sss_rst = `SSS_RST_AMP_SET;
      `SSS_ADDR_TRIM_LO: sss_rst = `SSS_RST_TRIM_LO;
      `SSS_ADDR_TRIM_MID: sss_rst = `SSS_RST_TRIM_MID;
      default: sss_rst = `SSS_RST_TRIM_HI;
    endcase
  endfunction

  // Frequently used fields of the running configuration
  assign master = active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_MASTER];
  assign tick = (div_r == `SSS_CLK_DIV);
  assign pin_now = {p3_s[1], p2_s[1], p1_s[1]};
  assign line_end = tick && (lp_cnt_r == 8'd0);
  assign start_rd = tick && (rd_st_r == sss_pkg::R_GAP) && pending_r;
  assign xfer_go = (rd_st_r == sss_pkg::R_GAP) && !pending_r;
  assign push = (rd_st_r == sss_pkg::R_ROW) && tick && fifo_in_ready;
  assign out_take = !line_valid_o || pix_ready_i;

  // Divide by four; the sequencer advances on one cycle of four
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      div_r <= 2'h0;
      seq_tick_o <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      seq_tick_o <= (div_r == `SSS_CLK_DIV - 2'h1);
    end
  end

  // Two-stage synchronisers for pins from the controller
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sclk_s <= 3'h0;
      sen_s <= 2'h0;
      sdat_s <= 2'h0;
      p1_s <= 2'h0;
      p2_s <= 2'h0;
      p3_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_clk_i};
      sen_s <= {sen_s[0], spi_en_i};
      sdat_s <= {sdat_s[0], spi_data_i};
      p1_s <= {p1_s[0], int_time_i};
      p2_s <= {p2_s[0], dual_slope_i};
      p3_s <= {p3_s[0], triple_slope_i};
    end
  end

  // Serial link: sample on rising edge, shift out on falling edge
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= 5'h00;
      rx_r <= 16'h0000;
      tx_r <= 12'h000;
      rd_mode_r <= 1'b0;
      spi_data_o <= 1'b0;
      spi_data_oe_n_o <= 1'b1;
    end else if (!sen_s[1]) begin
      bit_cnt_r <= 5'h00; // Frame ends with the enable
      rd_mode_r <= 1'b0;
      spi_data_oe_n_o <= 1'b1;
    end else begin
      if (sclk_s[1] && !sclk_s[2] && bit_cnt_r != `SSS_SPI_ALL_BITS) begin
        rx_r <= {rx_r[14:0], sdat_s[1]};
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == 5'h00) begin
          rd_mode_r <= sdat_s[1];
        end
        if (bit_cnt_r == `SSS_SPI_HDR_BITS - 5'h01) begin
          tx_r <= shadow_r[{rx_r[2:0], sdat_s[1]}];
        end
      end
      if (!sclk_s[1] && sclk_s[2] && rd_mode_r && bit_cnt_r >= `SSS_SPI_HDR_BITS) begin
        spi_data_o <= tx_r[11];
        tx_r <= {tx_r[10:0], 1'b0};
        spi_data_oe_n_o <= 1'b0;
      end
    end
  end

  // Shadow registers take whole serial writes
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 16; i++) begin
        shadow_r[i] <= sss_rst(4'(i));
      end
    end else if (sen_s[1] && sclk_s[1] && !sclk_s[2] && !rd_mode_r
                 && bit_cnt_r == `SSS_SPI_ALL_BITS - 5'h01) begin
      shadow_r[rx_r[14:11]] <= {rx_r[10:0], sdat_s[1]} & sss_mask(rx_r[14:11]);
    end
  end

  // Running copy follows the shadow only while no frame is read out, so a
  // write made during readout waits for the frame boundary
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 16; i++) begin
        active_r[i] <= sss_rst(4'(i));
      end
    end else if (rd_st_r == sss_pkg::R_GAP) begin
      for (int i = 0; i < 16; i++) begin
        active_r[i] <= shadow_r[i];
      end
    end
  end

  // Strobe levels as seen at the previous tick, for slave edges
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pin_prev_r <= 3'h0;
    end else if (tick) begin
      pin_prev_r <= pin_now;
    end
  end

  // Line period timer: one line is the kernel count plus row overhead plus one tick
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      lp_cnt_r <= 8'h00;
    end else if (tick) begin
      if (lp_cnt_r == 8'h00 || int_st_r == sss_pkg::I_WAIT) begin
        lp_cnt_r <= active_r[`SSS_ADDR_KERNEL_CNT][7:0] + `SSS_ROW_OVH_TICKS;
      end else begin
        lp_cnt_r <= lp_cnt_r - 8'h01;
      end
    end
  end

  // Integration engine: global reset, integrate, transfer to storage
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      int_st_r <= sss_pkg::I_WAIT;
      line_cnt_r <= 12'h000;
      ndr_armed_r <= 1'b0;
    end else if (tick) begin
      case (int_st_r)
        sss_pkg::I_WAIT: begin
          line_cnt_r <= 12'h000;
          // Restart at once when overlapping, else after readout ends
          if ((overlap_en_i || (rd_st_r == sss_pkg::R_GAP && !pending_r))
              && (master || (pin_now[0] && !pin_prev_r[0]))) begin
            if (active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_NDR] && ndr_armed_r) begin
              int_st_r <= sss_pkg::I_INTEG;
            end else begin
              int_st_r <= sss_pkg::I_RESET;
              ndr_armed_r <= active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_NDR];
            end
          end
          if (!active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_NDR]) begin
            ndr_armed_r <= 1'b0;
          end
        end
        sss_pkg::I_RESET: begin
          if (line_end) begin
            line_cnt_r <= line_cnt_r + 12'h001;
          end
          // Slave mode keeps the reset to one tick
          if (!master || (line_end && line_cnt_r + 12'h002
              >= active_r[`SSS_ADDR_RST_LEN])) begin
            int_st_r <= sss_pkg::I_INTEG;
          end
        end
        sss_pkg::I_INTEG: begin
          if (line_end) begin
            line_cnt_r <= line_cnt_r + 12'h001;
          end
          // Storage may be overwritten only once the last frame left it
          if (xfer_go && (master ? (line_cnt_r + 12'h001 >= active_r[`SSS_ADDR_FT_POS])
              : (!pin_now[0] && pin_prev_r[0]))) begin
            int_st_r <= sss_pkg::I_XFER;
          end
        end
        sss_pkg::I_XFER: begin
          int_st_r <= sss_pkg::I_WAIT;
        end
        default: begin
          int_st_r <= sss_pkg::I_WAIT;
        end
      endcase
    end
  end

  // Pixel-array strobes and master-mode strobe outputs
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pix_reset_o <= 1'b0;
      pix_sample_o <= 1'b0;
      dual_slope_reset_o <= 1'b0;
      triple_slope_reset_o <= 1'b0;
      int_time_o <= 1'b0;
      dual_slope_o <= 1'b0;
      triple_slope_o <= 1'b0;
      int_time_oe_n_o <= 1'b0;
      dual_slope_oe_n_o <= 1'b0;
      triple_slope_oe_n_o <= 1'b0;
    end else begin
      pix_reset_o <= (int_st_r == sss_pkg::I_RESET);
      // One clock of sampling per transfer, on the sequencer tick
      pix_sample_o <= tick && int_st_r == sss_pkg::I_XFER;
      // Extra resets at their programmed line, or slave rising edges
      dual_slope_reset_o <= tick && int_st_r == sss_pkg::I_INTEG
        && active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_DS_EN]
        && (master ? (line_end && line_cnt_r + 12'h001 == active_r[`SSS_ADDR_DS_POS])
        : (pin_now[1] && !pin_prev_r[1]));
      triple_slope_reset_o <= tick && int_st_r == sss_pkg::I_INTEG
        && active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_TS_EN]
        && (master ? (line_end && line_cnt_r + 12'h001 == active_r[`SSS_ADDR_TS_POS])
        : (pin_now[2] && !pin_prev_r[2]));
      // Pins driven only in master mode
      int_time_oe_n_o <= !master;
      dual_slope_oe_n_o <= !master;
      triple_slope_oe_n_o <= !master;
      int_time_o <= master && int_st_r == sss_pkg::I_INTEG;
      if (int_st_r != sss_pkg::I_INTEG) begin
        dual_slope_o <= 1'b0;
        triple_slope_o <= 1'b0;
      end else if (dual_slope_reset_o && master) begin
        dual_slope_o <= 1'b1;
      end else if (triple_slope_reset_o && master) begin
        triple_slope_o <= 1'b1;
      end
    end
  end

  // Sampled frame waiting for readout; the sample wins over the start
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pending_r <= 1'b0;
    end else if (tick && int_st_r == sss_pkg::I_XFER) begin
      pending_r <= 1'b1;
    end else if (start_rd) begin
      pending_r <= 1'b0;
    end
  end

  // Readout engine: rows in turn, kernels within a row
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rd_st_r <= sss_pkg::R_GAP;
      row_r <= 9'h000;
      rows_left_r <= 9'h000;
      kern_r <= 8'h00;
      blank_r <= 8'h00;
    end else if (tick) begin
      case (rd_st_r)
        sss_pkg::R_GAP: begin
          kern_r <= 8'h00;
          if (pending_r) begin
            rd_st_r <= sss_pkg::R_ROW;
            row_r <= shadow_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_REV_Y]
              ? `SSS_ROW_LAST - shadow_r[`SSS_ADDR_ROW_START][8:0]
              : shadow_r[`SSS_ADDR_ROW_START][8:0];
            rows_left_r <= `SSS_ROW_LAST - shadow_r[`SSS_ADDR_ROW_START][8:0];
          end
        end
        sss_pkg::R_ROW: begin
          if (fifo_in_ready) begin
            kern_r <= kern_r + 8'h01;
            if (kern_r + 8'h01 >= active_r[`SSS_ADDR_KERNEL_CNT][7:0]) begin
              rd_st_r <= sss_pkg::R_BLANK;
              blank_r <= `SSS_ROW_OVH_TICKS;
            end
          end
        end
        sss_pkg::R_BLANK: begin
          kern_r <= 8'h00;
          blank_r <= blank_r - 8'h01;
          if (blank_r == 8'h01) begin
            // Subsampling skips every other row
            if (active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_SUBSAMPLE]) begin
              rd_st_r <= (rows_left_r < 9'h002) ? sss_pkg::R_GAP : sss_pkg::R_ROW;
              rows_left_r <= rows_left_r - 9'h002;
              row_r <= active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_REV_Y]
                ? row_r - 9'h002 : row_r + 9'h002;
            end else begin
              rd_st_r <= (rows_left_r == 9'h000) ? sss_pkg::R_GAP : sss_pkg::R_ROW;
              rows_left_r <= rows_left_r - 9'h001;
              row_r <= active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_REV_Y]
                ? row_r - 9'h001 : row_r + 9'h001;
            end
          end
        end
        default: begin
          rd_st_r <= sss_pkg::R_GAP;
        end
      endcase
    end
  end

  // Array addresses and frame valid
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      row_addr_o <= 9'h000;
      col_addr_o <= 10'h000;
      frame_valid_o <= 1'b0;
    end else begin
      row_addr_o <= row_r;
      // Start counts in eight-pixel groups, width in four-pixel kernels
      col_addr_o <= active_r[`SSS_ADDR_SEQ_CTRL][`SSS_F_REV_X]
        ? `SSS_COL_LAST - (10'(active_r[`SSS_ADDR_COL_START][7:0]) << `SSS_COLS_PER_GROUP)
          - 10'(kern_r) * `SSS_PIX_PER_KERNEL
        : (10'(active_r[`SSS_ADDR_COL_START][7:0]) << `SSS_COLS_PER_GROUP)
          + 10'(kern_r) * `SSS_PIX_PER_KERNEL;
      frame_valid_o <= (rd_st_r != sss_pkg::R_GAP);
    end
  end

  // Converted kernels queue here; a full FIFO stalls the readout
  sss_fifo #(
    .W(`SSS_PIX_W),
    .D(`SSS_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(adc_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(out_take),
    .out_data_o(fifo_out_data)
  );

  // Output stage: line valid marks each word on the pixel port
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      line_valid_o <= 1'b0;
      pix_data_o <= '0;
    end else if (out_take) begin
      line_valid_o <= fifo_out_valid;
      pix_data_o <= fifo_out_valid ? fifo_out_data : '0;
    end
  end
endmodule

// ---- sim/sss_seq_monitor.sv ----
// Port checker of the snapshot sensor sequencer
`timescale 1ns/10ps
module sss_seq_monitor (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic spi_en_i,
  input wire logic pix_ready_i,
  input wire logic spi_data_oe_n_o,
  input wire logic int_time_o,
  input wire logic int_time_oe_n_o,
  input wire logic dual_slope_oe_n_o,
  input wire logic triple_slope_oe_n_o,
  input wire logic [9:0] pix_data_o,
  input wire logic line_valid_o,
  input wire logic frame_valid_o,
  input wire logic pix_reset_o,
  input wire logic pix_sample_o,
  input wire logic seq_tick_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  AST_LV_ZERO: assert property (!line_valid_o |-> pix_data_o == 10'h000)
    else $error("pixel word while line invalid");
  AST_LV_HOLD: assert property (line_valid_o && !pix_ready_i |=>
    line_valid_o && $stable(pix_data_o))
    else $error("pixel word dropped while stalled");
  AST_TICK: assert property (seq_tick_o |=> !seq_tick_o [*3] ##1 seq_tick_o)
    else $error("tick not every fourth clock");
  AST_OE_PAIR: assert property (int_time_oe_n_o == dual_slope_oe_n_o &&
    int_time_oe_n_o == triple_slope_oe_n_o)
    else $error("strobe directions differ");
  AST_RESET: assert property (disable iff (1'b0) !nrst_i |=> !frame_valid_o &&
    !line_valid_o && spi_data_oe_n_o && !pix_reset_o)
    else $error("outputs active in reset");
  AST_SAMPLE_PULSE: assert property (pix_sample_o |-> !pix_reset_o ##1 !pix_sample_o)
    else $error("sample pulse wrong");
  AST_SAMPLE_END: assert property ($rose(pix_sample_o) |-> ##[1:8] !int_time_o)
    else $error("integration not ended by transfer");
  AST_SPI_OE: assert property (!spi_en_i [*4] |-> spi_data_oe_n_o)
    else $error("serial pin driven while idle");
  AST_LV_IN_FRAME: assert property ($rose(line_valid_o) |-> frame_valid_o)
    else $error("pixel word outside a frame");
endmodule
bind sss_sequencer sss_seq_monitor u_mon (.clk_sys_i, .nrst_i, .spi_en_i, .pix_ready_i,
  .spi_data_oe_n_o, .int_time_o, .int_time_oe_n_o, .dual_slope_oe_n_o,
  .triple_slope_oe_n_o, .pix_data_o, .line_valid_o, .frame_valid_o, .pix_reset_o,
  .pix_sample_o, .seq_tick_o);

// ---- sim/sss_ctl_model.sv ----
// Camera controller model: serial frames and serial pin resolution
`timescale 1ns/10ps
module sss_ctl_model (
  input wire logic clk_sys_i,
  input wire logic dev_data_i,
  input wire logic dev_oe_n_i,
  output logic spi_clk_o,
  output logic spi_en_o,
  output logic pin_o
);
  logic drv = 1'b0; // Bit the model drives
  logic last = 1'b0; // Last wire level
  initial begin
    spi_clk_o = 1'b0;
    spi_en_o = 1'b0;
  end
  // Wire: device first, then model; undriven wire toggles
  always_comb pin_o = !dev_oe_n_i ? dev_data_i : (spi_en_o ? drv : ~last);
  always @(posedge clk_sys_i) last <= pin_o;
  // One frame, 6-clock phases keep the serial clock under 20 MHz
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [11:0] d,
    output logic [11:0] q);
    logic [16:0] f;
    f = {rd, a, d};
    q = 12'h000;
    spi_en_o <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      drv <= f[16-i];
      repeat (6) @(posedge clk_sys_i);
      if (i > 4) q[16-i] = pin_o;
      spi_clk_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      spi_clk_o <= 1'b0;
    end
    repeat (6) @(posedge clk_sys_i);
    spi_en_o <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

// ---- sim/testbench.sv ----
// Testbench: register table, frame readout with stall, subsampling, reset
`timescale 1ns/10ps
module testbench;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ov = 1'b0; // Overlap select
  logic rdy = 1'b1; // Capture ready
  logic [9:0] adc = 10'h155;
  logic sck, sen, pin, sdo, soe, lv, fv;
  logic [11:0] q;
  logic [15:0] nw = 16'h0000; // Words taken
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Reset value and read-back of the full write per address
  logic [23:0] rows [16] = '{24'h0297fb, 24'h0000ff, 24'h0001ff, 24'h0a00ff,
    24'h002fff, 24'h000fff, 24'h000fff, 24'h1e1fff, 24'h04a0ff, 24'h06b0ff,
    24'h0550ff, 24'h0f0fff, 24'hfb0fff, 24'hadffff, 24'h6dbfff, 24'h0db1ff};
  always #5 clk_sys_i = ~clk_sys_i;
  sss_ctl_model u_ctl (.clk_sys_i(clk_sys_i), .dev_data_i(sdo), .dev_oe_n_i(soe),
    .spi_clk_o(sck), .spi_en_o(sen), .pin_o(pin));
  sss_sequencer u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .spi_clk_i(sck),
    .spi_en_i(sen), .spi_data_i(pin), .spi_data_o(sdo), .spi_data_oe_n_o(soe),
    .int_time_i(1'b0), .int_time_o(), .int_time_oe_n_o(), .dual_slope_i(1'b0),
    .dual_slope_o(), .dual_slope_oe_n_o(), .triple_slope_i(1'b0), .triple_slope_o(),
    .triple_slope_oe_n_o(), .overlap_en_i(ov), .adc_data_i(adc), .pix_ready_i(rdy),
    .pix_data_o(), .line_valid_o(lv), .frame_valid_o(fv), .row_addr_o(),
    .col_addr_o(), .pix_reset_o(), .dual_slope_reset_o(), .triple_slope_reset_o(),
    .pix_sample_o(), .seq_tick_o());
  // Word counter, changing converter input, cycle ceiling
  always @(posedge clk_sys_i) begin
    if (lv === 1'b1 && rdy) nw <= nw + 16'h0001;
    adc <= adc + 10'h001;
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_fv(input logic lvl);
    int n;
    n = 0;
    while (fv !== lvl && n < 20000) begin
      @(posedge clk_sys_i);
      n++;
    end
    check("frame_valid", {15'h0000, fv}, {15'h0000, lvl});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    // Reset value, full write, read back masked, restore
    for (int a = 0; a < 16; a++) begin
      u_ctl.xfer(1'b1, a[3:0], 12'h000, q);
      check("reg_reset", {4'h0, q}, {4'h0, rows[a][23:12]});
      // Mode and granularity bits keep their defaults outside reset
      u_ctl.xfer(1'b0, a[3:0], (a == 0) ? 12'hffb : 12'hfff, q);
      u_ctl.xfer(1'b1, a[3:0], 12'h000, q);
      check("reg_width", {4'h0, q}, {4'h0, rows[a][11:0]});
      u_ctl.xfer(1'b0, a[3:0], rows[a][23:12], q);
    end
    // 40 kernels, rows 476..479, short transfer; capture stalls first
    rdy <= 1'b0;
    u_ctl.xfer(1'b0, 4'h3, 12'h028, q);
    u_ctl.xfer(1'b0, 4'h2, 12'h1dc, q);
    u_ctl.xfer(1'b0, 4'h7, 12'h003, q);
    wait_fv(1'b1);
    repeat (600) @(posedge clk_sys_i);
    check("stall_valid", {15'h0000, lv}, 16'h0001);
    nw = 16'h0000;
    rdy <= 1'b1;
    wait_fv(1'b0);
    // Words are drained before the gap; write at once, well before the next frame
    repeat (2) @(posedge clk_sys_i);
    check("frame_words", nw, 16'd160);
    // Subsampled frame keeps rows 476 and 478
    u_ctl.xfer(1'b0, 4'h0, 12'h02b, q);
    wait_fv(1'b1);
    nw = 16'h0000;
    wait_fv(1'b0);
    repeat (200) @(posedge clk_sys_i);
    check("subsample_words", nw, 16'd80);
    // Reset in mid-frame
    ov <= 1'b1;
    wait_fv(1'b1);
    nrst_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    check("reset_frame", {15'h0000, fv}, 16'h0000);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    u_ctl.xfer(1'b1, 4'h3, 12'h000, q);
    check("reset_reg", {4'h0, q}, 16'h00a0);
    final_report();
  end
endmodule
